// ### core/ccce_map.svh
// Offsets, field positions, reset values and opcode patterns of the executor.
// Included by the executor and its testbench; definitions only.
`ifndef CCCE_MAP_SVH
`define CCCE_MAP_SVH

// APB register byte offsets
`define CCCE_REG_CTRL 8'h00
`define CCCE_REG_PC 8'h04
`define CCCE_REG_ACC 8'h08
`define CCCE_REG_FLAGS 8'h0c
`define CCCE_REG_BANK 8'h10
`define CCCE_REG_SHADOW 8'h14
`define CCCE_REG_STACK 8'h18
`define CCCE_REG_WDOG 8'h1c
`define CCCE_REG_IDX 8'h20

// Control bits
`define CCCE_CTRL_RUN 0
`define CCCE_CTRL_EXT 1
`define CCCE_CTRL_RST 2'h0

// Flag bit positions
`define CCCE_F_C 0
`define CCCE_F_DC 1
`define CCCE_F_Z 2
`define CCCE_F_OV 3
`define CCCE_F_N 4
`define CCCE_FLAGS_RST 5'h00

// Program counter steps
`define CCCE_PC_STEP 21'h000002
`define CCCE_RET_STEP 21'h000004
`define CCCE_PC_RST 21'h000000

// Instruction patterns
`define CCCE_CALL_PFX 7'h76
`define CCCE_ZERO_PFX 7'h35
`define CCCE_INV_PFX 6'h07
`define CCCE_KICK_WORD 16'h0004
`define CCCE_BZ_PFX 8'he0
`define CCCE_BOV_PFX 8'he4
`define CCCE_WORD2_PFX 4'hf

// Access bank split and upper bank
`define CCCE_ACC_LIM 8'h5f
`define CCCE_UPPER_BANK 4'hf

`endif

// ### core/ccce_pkg.sv
// Types shared by the executor and its helpers.
// Assumes nothing of its surroundings.
package ccce_pkg;
  typedef enum logic [1:0] {
    ph_q1 = 2'b00,
    ph_q2 = 2'b01,
    ph_q3 = 2'b10,
    ph_q4 = 2'b11
  } ccce_phase_type;
  typedef enum logic {
    seq_run = 1'b0,
    seq_flush = 1'b1
  } ccce_seq_type;
  typedef enum logic [2:0] {
    op_none = 3'b000,
    op_call = 3'b001,
    zero_file_op = 3'b010,
    invert_file_op = 3'b011,
    kick_watchdog_op = 3'b100,
    op_branch = 3'b101
  } ccce_op_type;
endpackage

// ### core/ccce_links_if.sv
// Interfaces between the executor and its stack memory and watchdog.
// Both ends share ref_clk.
`timescale 1ns/1ps
interface ccce_stack_if;
  logic push;
  logic [4:0] waddr;
  logic [20:0] wdata;
  logic [4:0] raddr;
  logic [20:0] rdata;
  modport core(output push, output waddr, output wdata, output raddr, input rdata);
  modport mem(input push, input waddr, input wdata, input raddr, output rdata);
endinterface

interface ccce_wdog_if;
  logic kick;
  logic [7:0] count;
  logic [7:0] post;
  logic expire;
  modport core(output kick, input count, input post, input expire);
  modport dog(input kick, output count, output post, output expire);
endinterface

// ### core/ccce_stack_mem.sv
// Return stack storage with registered read data.
// Assumes the executor owns the stack pointer.
`timescale 1ns/1ps
module ccce_stack_mem import ccce_pkg::*; #(
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Stack port
  ccce_stack_if.mem stk
);
  logic [20:0] mem_ff [DEPTH];
  logic [20:0] rdata_ff;

  always_ff @(posedge ref_clk) begin
    if (stk.push) begin
      mem_ff[stk.waddr] <= stk.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_ff <= 21'h000000;
    end else begin
      rdata_ff <= mem_ff[stk.raddr];
    end
  end

  assign stk.rdata = rdata_ff;
endmodule // ccce_stack_mem

// ### core/ccce_wdog.sv
// Watchdog counter with prescale divider and postscaler, cleared by a kick.
// Assumes kick is a one-cycle pulse from the executor.
`timescale 1ns/1ps
module ccce_wdog import ccce_pkg::*; #(
  parameter int PRESCALE = 256,
  parameter logic [7:0] POST_LIMIT = 8'h0f
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Executor side
  ccce_wdog_if.dog wd
);
  localparam int PW = $clog2(PRESCALE);
  logic [PW-1:0] pre_ff;
  logic [7:0] count_ff;
  logic [7:0] post_ff;
  logic expire_ff;
  logic tick;
  logic wrap;

  assign tick = (int'(pre_ff) == PRESCALE - 1);
  assign wrap = tick && (count_ff == 8'hff);

  // Divider keeps running across kicks
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= tick ? '0 : pre_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || wd.kick) begin
      count_ff <= 8'h00;
      post_ff <= 8'h00;
      expire_ff <= 1'b0;
    end else begin
      expire_ff <= wrap && (post_ff == POST_LIMIT);
      if (tick) begin
        count_ff <= count_ff + 8'h01;
      end
      if (wrap) begin
        post_ff <= (post_ff == POST_LIMIT) ? 8'h00 : post_ff + 8'h01;
      end
    end
  end

  assign wd.count = count_ff;
  assign wd.post = post_ff;
  assign wd.expire = expire_ff;

  a_kick_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wd.kick |=> (count_ff == 8'h00) && (post_ff == 8'h00))
    else $error("Kick did not clear watchdog counter and postscaler");
endmodule // ccce_wdog

// ### core/ccce_exec.sv
// Executor for call, clear-file, watchdog-kick, invert-file and relative branch.
// Assumes program memory answers prog_addr in the same cycle and data memory
// returns read data one cycle after dmem_rd.
`timescale 1ns/1ps
`include "ccce_map.svh"

// Notes on behaviour
// - Call pushes pc plus four first
// - Shadow option copies accumulator, flags, bank
// - Call loads 20-bit target, bit0 zero
// - Call reaches whole program space
// - Call: two words, second cycle idle
// - Clear-file writes zero, sets zero flag
// - Clear-file decoded from 0110 101a
// - Selector zero access bank, one banked
// - Extended set: low addresses indexed
// - Kick clears watchdog counter and postscaler
// - Kick sets expiry and power-down flags unless an expiry lands in the same cycle
// - Invert-file, destination zero to accumulator
// - Invert-file, destination one back to file
// - Taken branch: pc plus two plus 2n
module ccce_exec import ccce_pkg::*; #(
  parameter int STACK_DEPTH = 32,
  parameter int DOG_PRESCALE = 256
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Program memory
  output logic [20:0] prog_addr,
  input wire logic [15:0] prog_data,
  // Data memory
  output logic [11:0] dmem_addr,
  output logic dmem_rd,
  input wire logic [7:0] dmem_rdata,
  output logic dmem_we,
  output logic [7:0] dmem_wdata
);
  ccce_phase_type phase_ff;
  ccce_seq_type seq_ff;
  ccce_op_type op_ff;
  logic [1:0] ctrl_ff;
  logic [20:0] pc_ff;
  logic [20:0] prog_addr_ff;
  logic [15:0] instr_ff;
  logic [7:0] acc_ff;
  logic [4:0] flags_ff;
  logic watchdog_expiry_flag_n;
  logic power_down_flag_n;
  logic [3:0] bank_select_reg;
  logic [7:0] accumulator_shadow;
  logic [4:0] flags_shadow;
  logic [3:0] bank_select_shadow;
  logic [4:0] sp_ff;
  logic [11:0] idx_base_ff;
  logic [11:0] dmem_addr_ff;
  logic [7:0] result_ff;
  logic [7:0] klo_ff;
  logic [31:0] prdata_ff;
  logic hit_ff;
  logic run;
  logic ext_en;
  logic q3_call;
  logic taken;
  logic [20:0] nxt_pc;
  logic [20:0] return_stack_top;
  logic apb_wr;

  ccce_stack_if stk();
  ccce_wdog_if wd();

  ccce_stack_mem #(.DEPTH(STACK_DEPTH)) u_stack (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .stk(stk.mem)
  );

  ccce_wdog #(.PRESCALE(DOG_PRESCALE)) u_wdog (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wd(wd.dog)
  );

  assign run = ctrl_ff[`CCCE_CTRL_RUN];
  assign ext_en = ctrl_ff[`CCCE_CTRL_EXT];
  assign return_stack_top = stk.rdata;

  function automatic ccce_op_type decode(input logic [15:0] w);
    ccce_op_type op;
    op = op_none;
    if (w[15:9] == `CCCE_CALL_PFX) begin
      op = op_call;
    end else if (w[15:9] == `CCCE_ZERO_PFX) begin
      op = zero_file_op;
    end else if (w[15:10] == `CCCE_INV_PFX) begin
      op = invert_file_op;
    end else if (w == `CCCE_KICK_WORD) begin
      op = kick_watchdog_op;
    end else if (w[15:8] == `CCCE_BZ_PFX || w[15:8] == `CCCE_BOV_PFX) begin
      op = op_branch;
    end
    // Lone second call word (prefix 1111) falls through as no-op
    return op;
  endfunction

  function automatic logic [11:0] file_addr(input logic [15:0] w, input logic ext,
                                            input logic [3:0] bank, input logic [11:0] base);
    logic [11:0] a;
    a = {bank, w[7:0]};
    if (!w[8]) begin
      if (ext && w[7:0] <= `CCCE_ACC_LIM) begin
        a = base + {4'h0, w[7:0]};
      end else if (w[7:0] <= `CCCE_ACC_LIM) begin
        a = {4'h0, w[7:0]};
      end else begin
        a = {`CCCE_UPPER_BANK, w[7:0]};
      end
    end
    return a;
  endfunction

  // Four-phase sequencer, frozen while run is low
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      phase_ff <= ph_q1;
    end else if (run) begin
      phase_ff <= ccce_phase_type'(phase_ff + 2'b01);
    end
  end

  // Fetch and decode at Q1; a flush cycle executes nothing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      op_ff <= op_none;
      instr_ff <= 16'h0000;
      dmem_addr_ff <= 12'h000;
    end else if (run && phase_ff == ph_q1) begin
      instr_ff <= prog_data;
      op_ff <= (seq_ff == seq_flush) ? op_none : decode(prog_data);
      dmem_addr_ff <= file_addr(prog_data, ext_en, bank_select_reg, idx_base_ff);
    end
  end

  assign q3_call = run && phase_ff == ph_q3 && op_ff == op_call;
  assign taken = (instr_ff[15:8] == `CCCE_BZ_PFX) ? flags_ff[`CCCE_F_Z]
                                                   : flags_ff[`CCCE_F_OV];

  // Program counter and flush marker, written at Q4
  always_comb begin
    nxt_pc = pc_ff + `CCCE_PC_STEP;
    unique case (op_ff)
      op_call: nxt_pc = {prog_data[11:0], klo_ff, 1'b0};
      op_branch: begin
        if (taken) begin
          nxt_pc = pc_ff + `CCCE_PC_STEP + {{12{instr_ff[7]}}, instr_ff[7:0], 1'b0};
        end
      end
      op_none: begin
        if (seq_ff == seq_flush) begin
          nxt_pc = pc_ff;
        end
      end
      zero_file_op, invert_file_op, kick_watchdog_op: nxt_pc = pc_ff + `CCCE_PC_STEP;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pc_ff <= `CCCE_PC_RST;
      seq_ff <= seq_run;
    end else if (run && phase_ff == ph_q4) begin
      pc_ff <= nxt_pc;
      seq_ff <= (op_ff == op_call || (op_ff == op_branch && taken)) ? seq_flush : seq_run;
    end
  end

  // Fetch address moves to the second call word during Q3
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prog_addr_ff <= `CCCE_PC_RST;
    end else if (q3_call) begin
      prog_addr_ff <= pc_ff + `CCCE_PC_STEP;
    end else if (run && phase_ff == ph_q4) begin
      prog_addr_ff <= nxt_pc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      klo_ff <= 8'h00;
    end else if (run && phase_ff == ph_q2 && op_ff == op_call) begin
      klo_ff <= instr_ff[7:0];
    end
  end

  // Return stack push; saturates at the top entry
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sp_ff <= 5'h00;
    end else if (q3_call && sp_ff != 5'(STACK_DEPTH - 1)) begin
      sp_ff <= sp_ff + 5'h01;
    end
  end

  assign stk.push = q3_call;
  assign stk.waddr = (sp_ff == 5'(STACK_DEPTH - 1)) ? sp_ff : sp_ff + 5'h01;
  assign stk.wdata = pc_ff + `CCCE_RET_STEP;
  assign stk.raddr = sp_ff;

  // Shadow copies only when the option bit is set
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      accumulator_shadow <= 8'h00;
      flags_shadow <= `CCCE_FLAGS_RST;
      bank_select_shadow <= 4'h0;
    end else if (q3_call && instr_ff[8]) begin
      accumulator_shadow <= acc_ff;
      flags_shadow <= flags_ff;
      bank_select_shadow <= bank_select_reg;
    end
  end

  // File read in Q2, processing in Q3, write-back in Q4
  assign dmem_rd = run && phase_ff == ph_q2 && (op_ff == invert_file_op);
  assign dmem_we = run && phase_ff == ph_q4 && (op_ff == zero_file_op ||
                   (op_ff == invert_file_op && instr_ff[9]));
  assign dmem_addr = dmem_addr_ff;
  assign dmem_wdata = result_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      result_ff <= 8'h00;
    end else if (run && phase_ff == ph_q3) begin
      result_ff <= (op_ff == invert_file_op) ? ~dmem_rdata : 8'h00;
    end
  end

  // Accumulator and flags; core writes win over software
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      acc_ff <= 8'h00;
      flags_ff <= `CCCE_FLAGS_RST;
    end else if (run && phase_ff == ph_q4 && op_ff == zero_file_op) begin
      flags_ff[`CCCE_F_Z] <= 1'b1;
    end else if (run && phase_ff == ph_q4 && op_ff == invert_file_op) begin
      if (!instr_ff[9]) begin
        acc_ff <= result_ff;
      end
      flags_ff[`CCCE_F_N] <= result_ff[7];
      flags_ff[`CCCE_F_Z] <= (result_ff == 8'h00);
    end else if (apb_wr && paddr == `CCCE_REG_ACC) begin
      acc_ff <= pwdata[7:0];
    end else if (apb_wr && paddr == `CCCE_REG_FLAGS) begin
      flags_ff <= pwdata[4:0];
    end
  end

  // Watchdog kick at Q3; an expiry in the same cycle still wins
  assign wd.kick = run && phase_ff == ph_q3 && op_ff == kick_watchdog_op;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      watchdog_expiry_flag_n <= 1'b1;
      power_down_flag_n <= 1'b1;
    end else if (wd.expire) begin
      watchdog_expiry_flag_n <= 1'b0;
    end else if (wd.kick) begin
      watchdog_expiry_flag_n <= 1'b1;
      power_down_flag_n <= 1'b1;
    end
  end

  // APB slave: zero wait states, error on unmapped offsets
  assign apb_wr = psel && penable && pwrite && pready;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_ff;
  assign prdata = prdata_ff;
  assign prog_addr = prog_addr_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_ff <= `CCCE_CTRL_RST;
      bank_select_reg <= 4'h0;
      idx_base_ff <= 12'h000;
    end else if (apb_wr) begin
      if (paddr == `CCCE_REG_CTRL) begin
        ctrl_ff <= pwdata[1:0];
      end
      if (paddr == `CCCE_REG_BANK) begin
        bank_select_reg <= pwdata[3:0];
      end
      if (paddr == `CCCE_REG_IDX) begin
        idx_base_ff <= pwdata[11:0];
      end
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata_ff <= 32'h00000000;
      hit_ff <= 1'b0;
    end else if (psel && !penable) begin
      hit_ff <= 1'b1;
      unique case (paddr)
        `CCCE_REG_CTRL: prdata_ff <= {30'h0, ctrl_ff};
        `CCCE_REG_PC: prdata_ff <= {11'h0, pc_ff};
        `CCCE_REG_ACC: prdata_ff <= {24'h0, acc_ff};
        `CCCE_REG_FLAGS: prdata_ff <= {25'h0, power_down_flag_n, watchdog_expiry_flag_n, flags_ff};
        `CCCE_REG_BANK: prdata_ff <= {28'h0, bank_select_reg};
        `CCCE_REG_SHADOW: prdata_ff <= {15'h0, bank_select_shadow, flags_shadow, accumulator_shadow};
        `CCCE_REG_STACK: prdata_ff <= {6'h0, sp_ff, return_stack_top};
        `CCCE_REG_WDOG: prdata_ff <= {16'h0, wd.post, wd.count};
        `CCCE_REG_IDX: prdata_ff <= {20'h0, idx_base_ff};
        default: begin
          prdata_ff <= 32'h00000000;
          hit_ff <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Checks the pushed entry as it comes back out of the stack memory
  a_call_push: assert property (q3_call && stk.push
    |-> ##2 return_stack_top == $past(pc_ff, 2) + 21'h000004)
    else $error("Call did not push pc plus four");
  a_shadow_hold: assert property (q3_call && !instr_ff[8] |=> $stable(accumulator_shadow) && $stable(flags_shadow))
    else $error("Shadow changed without option bit");
  a_shadow_copy: assert property (q3_call && instr_ff[8] |=> accumulator_shadow == $past(acc_ff))
    else $error("Shadow copy missing");
  a_call_target: assert property (run && phase_ff == ph_q4 && op_ff == op_call
    |=> pc_ff == {$past(prog_data[11:0]), $past(klo_ff), 1'b0} && seq_ff == seq_flush)
    else $error("Call target not loaded");
  a_flush_idle: assert property (run && phase_ff == ph_q1 && seq_ff == seq_flush
    |=> op_ff == op_none)
    else $error("Flush cycle executed an operation");
  a_clear_file: assert property (dmem_we && op_ff == zero_file_op
    |-> dmem_wdata == 8'h00 ##1 flags_ff[`CCCE_F_Z])
    else $error("Clear-file wrong data or zero flag");
  a_bank_addr: assert property (run && phase_ff == ph_q1 && prog_data[8]
    |=> dmem_addr == {$past(bank_select_reg), $past(prog_data[7:0])})
    else $error("Banked address wrong");
  a_indexed_addr: assert property (run && phase_ff == ph_q1 && !prog_data[8] && ext_en
    && prog_data[7:0] <= 8'h5f |=> dmem_addr == $past(idx_base_ff) + {4'h0, $past(prog_data[7:0])})
    else $error("Indexed address wrong");
  a_kick_flags: assert property (wd.kick && !wd.expire |=> watchdog_expiry_flag_n && power_down_flag_n)
    else $error("Kick did not set status flags");
  a_invert_dest: assert property (run && phase_ff == ph_q4 && op_ff == invert_file_op
    |-> dmem_we == instr_ff[9] && dmem_wdata == ~$past(dmem_rdata))
    else $error("Invert-file destination wrong");
  a_branch_taken: assert property (run && phase_ff == ph_q4 && op_ff == op_branch && taken
    |=> pc_ff == $past(pc_ff) + 21'h000002 + {{12{$past(instr_ff[7])}}, $past(instr_ff[7:0]), 1'b0})
    else $error("Branch target wrong");

  c_call_shadow: cover property (q3_call && instr_ff[8]);
  c_invert_acc: cover property (run && phase_ff == ph_q4 && op_ff == invert_file_op && !instr_ff[9]);
  c_kick: cover property (wd.kick);
  c_branch: cover property (run && phase_ff == ph_q4 && op_ff == op_branch && taken);
endmodule // ccce_exec

// ### testbench/ccce_mem_model.sv
// Program and data memory model facing the executor.
// Assumes one clock; program words answer at once, data one cycle after a read.
`timescale 1ns/1ps
module ccce_mem_model (
  // Clock
  input wire logic ref_clk,
  // Program memory
  input wire logic [20:0] prog_addr,
  output logic [15:0] prog_data,
  // Data memory
  input wire logic [11:0] dmem_addr,
  input wire logic dmem_rd,
  output logic [7:0] dmem_rdata,
  input wire logic dmem_we,
  input wire logic [7:0] dmem_wdata
);
  logic [15:0] prog [logic [20:0]];
  logic [7:0] dmem [4096];
  int rev = 0;

  task automatic load(input logic [20:0] a, input logic [15:0] w);
    prog[a] = w;
    rev++;
  endtask

  // Rev forces a new answer when the word under a parked address changes
  always @(prog_addr or rev) begin
    prog_data = prog.exists(prog_addr) ? prog[prog_addr] : 16'h0000;
  end

  initial begin
    dmem_rdata = 8'h00;
    foreach (dmem[i]) begin
      dmem[i] = 8'h00;
    end
  end

  // Outside the read slot the bus toggles so a late sample shows up
  always @(posedge ref_clk) begin
    if (dmem_rd === 1'b1) begin
      dmem_rdata <= dmem[dmem_addr];
    end else begin
      dmem_rdata <= ~dmem_rdata;
    end
    if (dmem_we === 1'b1) begin
      dmem[dmem_addr] <= dmem_wdata;
    end
  end
endmodule // ccce_mem_model

// ### testbench/test_ccce_exec.sv
// Self-checking bench for the executor: APB register access, a short program, watchdog.
// Assumes ccce_mem_model stands for program and data memory.
`timescale 1ns/1ps
`include "ccce_map.svh"
module test_ccce_exec import ccce_pkg::*;;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, watch;
  logic dmem_rd, dmem_we;
  logic [7:0] paddr, dmem_rdata, dmem_wdata, r1;
  logic [31:0] pwdata, prdata, d;
  logic [20:0] prog_addr;
  logic [15:0] prog_data;
  logic [11:0] dmem_addr, idx;
  logic [64:0] rq [$];
  logic [19:0] dq [$];
  logic [64:0] note;
  logic [19:0] wnote;
  int mismatches = 0;
  int checks = 0;
  int seed, n;

  ccce_exec #(.DOG_PRESCALE(4)) ccce_exec_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
    .prog_data(prog_data), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_rdata(dmem_rdata), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata));

  ccce_mem_model ccce_mem_model_inst (.ref_clk(ref_clk), .prog_addr(prog_addr),
    .prog_data(prog_data), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_rdata(dmem_rdata), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Entered just after a rising edge; leaves just after one
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    k = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge ref_clk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                        input logic err);
    logic [31:0] x;
    rq.push_back({err, m, e});
    watch = 1'b1;
    apb(a, 1'b0, 32'h0, x);
    watch = 1'b0;
  endtask

  // Scoreboard: register reads and data memory writes
  always @(posedge ref_clk) begin
    if (watch && psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
      note = rq.pop_front();
      checks++;
      if (((prdata & note[63:32]) !== note[31:0]) || (pslverr !== note[64])) begin
        mismatches++;
        $display("mismatch at %0t: read %h gave %h err %b", $time, paddr, prdata, pslverr);
      end
    end
    if (dmem_we === 1'b1) begin
      wnote = (dq.size() > 0) ? dq.pop_front() : 20'hfffff;
      checks++;
      if ({dmem_addr, dmem_wdata} !== wnote) begin
        mismatches++;
        $display("mismatch at %0t: write %h=%h", $time, dmem_addr, dmem_wdata);
      end
    end
  end

  initial begin
    #(25ns * 30000);
    mismatches++;
    $display("mismatch at %0t: run did not finish", $time);
    wrap_up();
  end

  initial begin
    seed = 95;
    watch = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    // Reset values; watchdog count and never-written stack entry masked, 0x24 unmapped
    for (int i = 0; i < 10; i++) begin
      rd_chk(8'(i * 4), (i == 3) ? 32'h60 : 32'h0,
             (i == 7) ? 32'h0 : (i == 6) ? 32'hffe00000 : 32'hffffffff, i == 9);
    end
    $display("test reset values done");
    idx = 12'h400 | 12'($random(seed) & 32'h3ff);
    r1 = 8'($random(seed));
    ccce_mem_model_inst.dmem[idx + 12'h020] = r1;
    ccce_mem_model_inst.dmem[12'hf80] = 8'hff;
    ccce_mem_model_inst.load(21'h000000, 16'h6b12);
    ccce_mem_model_inst.load(21'h000002, 16'h6a10);
    ccce_mem_model_inst.load(21'h000004, 16'h1e20);
    ccce_mem_model_inst.load(21'h000006, 16'h1c80);
    ccce_mem_model_inst.load(21'h000008, 16'h0004);
    ccce_mem_model_inst.load(21'h00000a, 16'hed40);
    ccce_mem_model_inst.load(21'h00000c, 16'hf800);
    ccce_mem_model_inst.load(21'h100080, 16'hf123);
    ccce_mem_model_inst.load(21'h100082, 16'he002);
    ccce_mem_model_inst.load(21'h100088, 16'he4ff);
    dq.push_back({12'h312, 8'h00});
    dq.push_back({idx + 12'h010, 8'h00});
    dq.push_back({idx + 12'h020, ~r1});
    apb(`CCCE_REG_IDX, 1'b1, {20'h0, idx}, d);
    apb(`CCCE_REG_BANK, 1'b1, 32'h3, d);
    apb(`CCCE_REG_FLAGS, 1'b1, 32'h0b, d);
    apb(`CCCE_REG_ACC, 1'b1, 32'h5a, d);
    apb(`CCCE_REG_CTRL, 1'b1, 32'h3, d);
    // Program ends parked on a branch to itself
    n = 0;
    d = 32'h0;
    while (d !== 32'h00100088 && n < 100) begin
      apb(`CCCE_REG_PC, 1'b0, 32'h0, d);
      n++;
    end
    rd_chk(`CCCE_REG_PC, 32'h00100088, 32'h001fffff, 1'b0);
    rd_chk(`CCCE_REG_STACK, 32'h0020000e, 32'h03ffffff, 1'b0);
    rd_chk(`CCCE_REG_SHADOW, 32'h00006f00, 32'h0001ffff, 1'b0);
    rd_chk(`CCCE_REG_ACC, 32'h0, 32'hff, 1'b0);
    rd_chk(`CCCE_REG_FLAGS, 32'h6f, 32'h7f, 1'b0);
    rd_chk(`CCCE_REG_BANK, 32'h3, 32'hf, 1'b0);
    checks++;
    if (dq.size() != 0) begin
      mismatches++;
      $display("mismatch at %0t: %0d writes missing", $time, dq.size());
    end
    $display("test program done");
    // Let the watchdog run out, then swap the parked word for a kick
    repeat (4 * 256 * 17) @(posedge ref_clk);
    rd_chk(`CCCE_REG_FLAGS, 32'h40, 32'h60, 1'b0);
    ccce_mem_model_inst.load(21'h100088, 16'h0004);
    repeat (20) @(posedge ref_clk);
    rd_chk(`CCCE_REG_FLAGS, 32'h60, 32'h60, 1'b0);
    rd_chk(`CCCE_REG_WDOG, 32'h0, 32'hfff8, 1'b0);
    $display("test watchdog kick done");
    wrap_up();
  end
endmodule // test_ccce_exec
